/* rtl/dmp_exec.v */
// Execution unit for irq-disable, dual MAC, word move and protect ops
`timescale 1ns/1ns
`default_nettype none
`include "dmp_regs.vh"

module dmp_exec
(
  input wire I_CLK,
  input wire I_RST,
  // Decoded instruction
  input wire I_OP_VALID,
  input wire [15:0] I_OP_WORD0,
  input wire [15:0] I_OP_WORD1,
  input wire I_REP_VALID,
  input wire [15:0] I_REP_N,
  input wire [21:0] I_OPND_ADDR,
  input wire [21:0] I_OPND_STEP,
  input wire I_OPND_IS_REG,
  input wire [31:0] I_OPND_REG_DATA,
  input wire I_OPND_PTR7,
  // Data memory
  output wire [21:0] O_DMEM_ADDR,
  output wire O_DMEM_RD,
  input wire [31:0] I_DMEM_RDATA,
  output wire [21:0] O_DMEM_WADDR,
  output wire O_DMEM_WR,
  output wire [15:0] O_DMEM_WDATA,
  // Program memory
  output wire [21:0] O_PMEM_ADDR,
  output wire O_PMEM_RD,
  input wire [31:0] I_PMEM_RDATA,
  // Interrupt entry and return
  input wire I_INT_ENTRY,
  input wire I_IRQ_RET,
  input wire [15:0] I_RET_STAT,
  input wire I_DBG_OVR,
  input wire I_DBG_PROT,
  output wire [15:0] O_STAT_SAVE,
  output wire O_IRQ_MASK,
  output wire O_PROT_WR_OK,
  output wire O_PROT_RD_OK,
  output wire O_ILLEGAL_TRAP,
  output wire O_BUSY,
  // Register port
  input wire [2:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output wire [31:0] O_RDATA
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_WAIT = 4'h2;
  localparam [3:0] S_MAC = 4'h4;
  localparam [3:0] S_MOV = 4'h8;

  // Scale a product by the shift-select field
  function [31:0] prod_shift;
    input [31:0] p;
    input [2:0] sel;
    reg [2:0] amt;
    begin
      amt = sel - 3'h1;
      case (sel)
        3'h0: prod_shift = {p[30:0], 1'b0};
        3'h1: prod_shift = p;
        default: prod_shift = $signed(p) >>> amt;
      endcase
    end
  endfunction

  reg [3:0] state_q;
  reg [2:0] wait_q;
  reg [15:0] rep_q;
  reg [31:0] sum_q;
  reg [31:0] prd_q;
  reg [31:0] mcand_q;
  reg [31:0] ptr7_q;
  reg sat_q;
  reg [2:0] shsel_q;
  reg z_q;
  reg n_q;
  reg c_q;
  reg v_q;
  reg [5:0] tally_q;
  reg imask_q;
  reg prot_q;
  reg [21:0] daddr_q;
  reg [21:0] dstep_q;
  reg pinc_q;
  reg ptr7_by_opnd_q;
  reg opnd_reg_q;
  reg [31:0] opnd_val_q;
  reg mac2_q;
  reg mov2_q;
  reg [21:0] rdaddr_q;
  reg wr_q;
  reg [21:0] waddr_q;
  reg [15:0] wdata_q;
  reg trap_q;
  reg [31:0] rdata_q;
  reg dbg_ovr_s1_q;
  reg dbg_ovr_q;
  reg dbg_prot_s1_q;
  reg dbg_prot_q;

  wire idle = (state_q == S_IDLE);
  wire accept = I_OP_VALID && idle && !mac2_q && !mov2_q && !wr_q;
  wire is_idis = (I_OP_WORD0 == `DMP_OP_IDIS);
  wire is_prot = (I_OP_WORD0 == `DMP_OP_PROT);
  wire is_mac = (I_OP_WORD0 == `DMP_OP_MAC0) &&
    ((I_OP_WORD1[15:8] == `DMP_OP_MAC_PLAIN) ||
    (I_OP_WORD1[15:8] == `DMP_OP_MAC_PINC));
  wire is_mov = (I_OP_WORD0[15:8] == `DMP_OP_MOV);
  wire [15:0] rep_n = I_REP_VALID ? I_REP_N : 16'h0000;
  wire reg_wr = I_WR;

  // Status word one as seen by software and the interrupt save path
  wire [15:0] stat = {prot_q, imask_q, tally_q, v_q, c_q, n_q, z_q,
    shsel_q, sat_q};

  // Second MAC stage: both products from the data operand, fetched or register, and the program word
  wire [31:0] mcand_in = opnd_reg_q ? opnd_val_q : I_DMEM_RDATA;
  wire [31:0] t_op = I_PMEM_RDATA;
  wire signed [31:0] p_hi = $signed(mcand_in[31:16]) * $signed(t_op[31:16]);
  wire signed [31:0] p_lo = $signed(mcand_in[15:0]) * $signed(t_op[15:0]);
  wire [31:0] sh_hi = prod_shift(p_hi, shsel_q);
  wire [31:0] sh_lo = prod_shift(p_lo, shsel_q);
  wire [32:0] add_hi = {1'b0, sum_q} + {1'b0, sh_hi};
  wire [31:0] add_lo = prd_q + sh_lo;
  wire pos_ov = !sum_q[31] && !sh_hi[31] && add_hi[31];
  wire neg_ov = sum_q[31] && sh_hi[31] && !add_hi[31];
  reg [31:0] sum_new;

  // Saturation touches the sum only, never the product register
  always @*
  begin
    sum_new = add_hi[31:0];
    if (sat_q && pos_ov)
      sum_new = 32'h7FFFFFFF;
    else if (sat_q && neg_ov)
      sum_new = 32'h80000000;
  end

  // Debug override arrives from the test-port logic, so synchronise it
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      dbg_ovr_s1_q <= 1'b0;
      dbg_ovr_q <= 1'b0;
      dbg_prot_s1_q <= 1'b0;
      dbg_prot_q <= 1'b0;
    end
    else
    begin
      dbg_ovr_s1_q <= I_DBG_OVR;
      dbg_ovr_q <= dbg_ovr_s1_q;
      dbg_prot_s1_q <= I_DBG_PROT;
      dbg_prot_q <= dbg_prot_s1_q;
    end
  end

  // Sequencer: issue stage of MAC and move, and the fixed-length ops
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q <= S_IDLE;
      wait_q <= 3'h0;
      rep_q <= 16'h0000;
      daddr_q <= 22'h000000;
      dstep_q <= 22'h000000;
      pinc_q <= 1'b0;
      ptr7_by_opnd_q <= 1'b0;
      opnd_reg_q <= 1'b0;
      opnd_val_q <= `DMP_RST_W32;
      mac2_q <= 1'b0;
      mov2_q <= 1'b0;
      rdaddr_q <= 22'h000000;
      trap_q <= 1'b0;
    end
    else
    begin
      trap_q <= 1'b0;
      mac2_q <= 1'b0;
      mov2_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (accept)
          begin
            daddr_q <= I_OPND_ADDR;
            dstep_q <= I_OPND_STEP;
            opnd_reg_q <= I_OPND_IS_REG;
            opnd_val_q <= I_OPND_REG_DATA;
            ptr7_by_opnd_q <= I_OPND_PTR7;
            pinc_q <= (I_OP_WORD1[15:8] == `DMP_OP_MAC_PINC);
            if (is_mac)
            begin
              rep_q <= rep_n;
              state_q <= S_MAC;
            end
            else if (is_mov && I_OPND_IS_REG)
            begin
              trap_q <= 1'b1;
              rep_q <= 16'h0000;
            end
            else if (is_mov)
            begin
              rep_q <= rep_n;
              state_q <= S_MOV;
            end
            else if (is_idis || is_prot)
            begin
              rep_q <= 16'h0000;
              wait_q <= is_idis ? `DMP_CYC_IDIS - 3'h1
                : `DMP_CYC_PROT - 3'h1;
              state_q <= S_WAIT;
            end
            else
              rep_q <= 16'h0000;
          end
        end
        S_WAIT:
        begin
          wait_q <= wait_q - 3'h1;
          if (wait_q == 3'h0)
            state_q <= S_IDLE;
        end
        S_MAC, S_MOV:
        begin
          // One read per cycle; the result stage trails by one cycle
          mac2_q <= (state_q == S_MAC);
          mov2_q <= (state_q == S_MOV);
          rdaddr_q <= daddr_q;
          daddr_q <= daddr_q + dstep_q;
          if (rep_q == 16'h0000)
            state_q <= S_IDLE;
          else
            rep_q <= rep_q - 16'h0001;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Word move write-back: registered so the write port holds flop data
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      wr_q <= 1'b0;
      waddr_q <= 22'h000000;
      wdata_q <= 16'h0000;
    end
    else
    begin
      wr_q <= mov2_q;
      if (mov2_q)
      begin
        waddr_q <= rdaddr_q + 22'h000001;
        wdata_q <= I_DMEM_RDATA[15:0];
      end
    end
  end

  // Datapath registers; core events win over a software write
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      sum_q <= `DMP_RST_W32;
      prd_q <= `DMP_RST_W32;
      mcand_q <= `DMP_RST_W32;
      ptr7_q <= `DMP_RST_W32;
    end
    else
    begin
      if (reg_wr && I_ADDR == `DMP_OFS_SUM)
        sum_q <= I_WDATA;
      if (reg_wr && I_ADDR == `DMP_OFS_PRD)
        prd_q <= I_WDATA;
      if (reg_wr && I_ADDR == `DMP_OFS_MCAND)
        mcand_q <= I_WDATA;
      if (reg_wr && I_ADDR == `DMP_OFS_PTR7)
        ptr7_q <= I_WDATA;
      if (state_q == S_MAC)
      begin
        if (ptr7_by_opnd_q)
          ptr7_q <= ptr7_q + {10'h000, dstep_q};
        else if (pinc_q)
          ptr7_q <= ptr7_q + {10'h000, `DMP_PTR_STEP};
      end
      if (mac2_q)
      begin
        mcand_q <= mcand_in;
        sum_q <= sum_new;
        prd_q <= add_lo;
      end
    end
  end

  // Status word one: flags, tally, modes, mask and protect bit
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      sat_q <= 1'b0;
      shsel_q <= `DMP_RST_SHSEL;
      z_q <= 1'b0;
      n_q <= 1'b0;
      c_q <= 1'b0;
      v_q <= 1'b0;
      tally_q <= `DMP_RST_TALLY;
      imask_q <= `DMP_RST_IMASK;
      prot_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && I_ADDR == `DMP_OFS_STAT)
      begin
        sat_q <= I_WDATA[`DMP_ST_SAT];
        shsel_q <= I_WDATA[`DMP_ST_SHH:`DMP_ST_SHL];
        z_q <= I_WDATA[`DMP_ST_Z];
        n_q <= I_WDATA[`DMP_ST_N];
        c_q <= I_WDATA[`DMP_ST_C];
        v_q <= I_WDATA[`DMP_ST_V];
        tally_q <= I_WDATA[`DMP_ST_TLYH:`DMP_ST_TLYL];
        imask_q <= I_WDATA[`DMP_ST_IMASK];
        prot_q <= I_WDATA[`DMP_ST_PROT];
      end
      // Flags come from the sum half only
      if (mac2_q)
      begin
        z_q <= (sum_new == 32'h00000000);
        n_q <= sum_new[31];
        c_q <= add_hi[32];
        if (pos_ov || neg_ov)
          v_q <= 1'b1;
        if (!sat_q && pos_ov)
          tally_q <= tally_q + 6'h01;
        else if (!sat_q && neg_ov)
          tally_q <= tally_q - 6'h01;
      end
      if (accept && is_idis)
        imask_q <= 1'b1;
      if (I_IRQ_RET)
        prot_q <= I_RET_STAT[`DMP_ST_PROT];
      if (accept && is_prot)
        prot_q <= 1'b1;
      // Entry clears last: the saved copy holds the prior value
      if (I_INT_ENTRY)
        prot_q <= 1'b0;
    end
  end

  // Register read data, one cycle after the strobe; gaps read as zero
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      rdata_q <= `DMP_RST_W32;
    else if (I_RD)
    begin
      case (I_ADDR)
        `DMP_OFS_SUM: rdata_q <= sum_q;
        `DMP_OFS_PRD: rdata_q <= prd_q;
        `DMP_OFS_MCAND: rdata_q <= mcand_q;
        `DMP_OFS_PTR7: rdata_q <= ptr7_q;
        `DMP_OFS_STAT: rdata_q <= {16'h0000, stat};
        `DMP_OFS_REP: rdata_q <= {16'h0000, rep_q};
        default: rdata_q <= `DMP_RST_W32;
      endcase
    end
    else
      rdata_q <= `DMP_RST_W32;
  end

  // Program fetch spans 22 bits of pointer seven
  assign O_PMEM_ADDR = ptr7_q[21:0];
  assign O_PMEM_RD = (state_q == S_MAC) && !opnd_reg_q;
  assign O_DMEM_ADDR = daddr_q;
  assign O_DMEM_RD = ((state_q == S_MAC) && !opnd_reg_q) ||
    (state_q == S_MOV);
  assign O_DMEM_WADDR = waddr_q;
  assign O_DMEM_WR = wr_q;
  assign O_DMEM_WDATA = wdata_q;
  assign O_STAT_SAVE = stat;
  assign O_IRQ_MASK = imask_q;
  // Debug host override of the write gate; reads are never gated
  assign O_PROT_WR_OK = dbg_ovr_q ? dbg_prot_q : prot_q;
  assign O_PROT_RD_OK = 1'b1;
  assign O_ILLEGAL_TRAP = trap_q;
  assign O_BUSY = !idle || mac2_q || mov2_q || wr_q;
  assign O_RDATA = rdata_q;

endmodule

`default_nettype wire

/* inc/dmp_regs.vh */
// Constants for the dual-MAC, word-move and protect execution unit
`ifndef DMP_REGS_VH
`define DMP_REGS_VH

// Register offsets on the plain register port
`define DMP_OFS_SUM 3'h0
`define DMP_OFS_PRD 3'h1
`define DMP_OFS_MCAND 3'h2
`define DMP_OFS_PTR7 3'h3
`define DMP_OFS_STAT 3'h4
`define DMP_OFS_REP 3'h5

// Status word one field positions
`define DMP_ST_SAT 0
`define DMP_ST_SHL 1
`define DMP_ST_SHH 3
`define DMP_ST_Z 4
`define DMP_ST_N 5
`define DMP_ST_C 6
`define DMP_ST_V 7
`define DMP_ST_TLYL 8
`define DMP_ST_TLYH 13
`define DMP_ST_IMASK 14
`define DMP_ST_PROT 15

// Reset values
`define DMP_RST_W32 32'h00000000
`define DMP_RST_SHSEL 3'h0
`define DMP_RST_TALLY 6'h00
`define DMP_RST_IMASK 1'b1

// Opcodes
`define DMP_OP_IDIS 16'h3B10
`define DMP_OP_MAC0 16'h564B
`define DMP_OP_MAC_PLAIN 8'hC7
`define DMP_OP_MAC_PINC 8'h87
`define DMP_OP_MOV 8'hA5
`define DMP_OP_PROT 16'h7622

// Cycle counts and pointer step
`define DMP_CYC_IDIS 3'h2
`define DMP_CYC_PROT 3'h4
`define DMP_PTR_STEP 22'h000002

`endif

/* testbench/dmp_exec_props.sv */
// Port-level property checker for the execution unit
`timescale 1ns/1ns
`default_nettype none
`include "dmp_regs.vh"
module dmp_exec_props
(
  input wire I_CLK,
  input wire I_RST,
  input wire I_OP_VALID,
  input wire [15:0] I_OP_WORD0,
  input wire I_REP_VALID,
  input wire [21:0] I_OPND_ADDR,
  input wire I_OPND_IS_REG,
  input wire I_INT_ENTRY,
  input wire I_IRQ_RET,
  input wire [15:0] I_RET_STAT,
  input wire I_DBG_OVR,
  input wire O_DMEM_RD,
  input wire O_PMEM_RD,
  input wire O_DMEM_WR,
  input wire [21:0] O_DMEM_WADDR,
  input wire O_PROT_WR_OK,
  input wire O_ILLEGAL_TRAP,
  input wire O_BUSY
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // An op is taken only while the unit is idle
  wire take;
  wire mac;
  wire mov;
  assign take = I_OP_VALID && !O_BUSY;
  assign mac = take && I_OP_WORD0 == `DMP_OP_MAC0;
  assign mov = take && I_OP_WORD0[15:8] == `DMP_OP_MOV;

  a_idis_length: assert property (take && I_OP_WORD0 == `DMP_OP_IDIS
    |=> O_BUSY[*2] ##1 !O_BUSY) else $error("irq disable length wrong");
  a_prot_length: assert property (take && I_OP_WORD0 == `DMP_OP_PROT
    |=> O_BUSY[*4] ##1 !O_BUSY) else $error("protect op length wrong");
  a_prot_set: assert property (take && I_OP_WORD0 == `DMP_OP_PROT
    && !I_DBG_OVR |-> ##[1:4] O_PROT_WR_OK) else $error("write gate not set");
  a_entry_clear: assert property (I_INT_ENTRY && !I_DBG_OVR
    |=> !O_PROT_WR_OK) else $error("entry left write gate open");
  a_ret_restore: assert property (I_IRQ_RET && !I_INT_ENTRY
    && !I_DBG_OVR |=> O_PROT_WR_OK == $past(I_RET_STAT[15]))
    else $error("return did not restore write gate");
  a_mac_fetch: assert property (mac && !I_OPND_IS_REG
    |=> O_DMEM_RD && O_PMEM_RD) else $error("mac operand fetch missing");
  a_mac_length: assert property (mac && !I_REP_VALID
    |=> O_BUSY ##1 O_BUSY ##1 !O_BUSY) else $error("mac length wrong");
  a_move_write: assert property (mov && !I_OPND_IS_REG
    |-> ##3 O_DMEM_WR && O_DMEM_WADDR == $past(I_OPND_ADDR, 3) + 22'h1)
    else $error("move write misplaced");
  a_move_trap: assert property (mov && I_OPND_IS_REG
    |=> O_ILLEGAL_TRAP ##1 !O_ILLEGAL_TRAP) else $error("move trap missing");
endmodule

bind dmp_exec dmp_exec_props dmp_exec_props_inst (.I_CLK, .I_RST,
  .I_OP_VALID, .I_OP_WORD0, .I_REP_VALID, .I_OPND_ADDR, .I_OPND_IS_REG,
  .I_INT_ENTRY, .I_IRQ_RET, .I_RET_STAT, .I_DBG_OVR, .O_DMEM_RD, .O_PMEM_RD,
  .O_DMEM_WR, .O_DMEM_WADDR, .O_PROT_WR_OK, .O_ILLEGAL_TRAP, .O_BUSY);
`default_nettype wire

/* testbench/dmp_mem_model.sv */
// Unified program and data memory model beside the execution unit
`timescale 1ns/1ns
`default_nettype none
module dmp_mem_model
(
  input wire logic i_clk,
  input wire logic [21:0] i_daddr,
  input wire logic i_drd,
  input wire logic [21:0] i_waddr,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic [21:0] i_paddr,
  input wire logic i_prd,
  output logic [31:0] o_ddata,
  output logic [31:0] o_pdata
);
  logic [15:0] mem [0:63];
  initial
  begin
    o_ddata = 32'h0;
    o_pdata = 32'h0;
  end
  // Data stand one cycle after a strobe; an idle bus toggles so stale
  // values do not hold steady
  always @(posedge i_clk)
  begin
    o_ddata <= i_drd ? {mem[i_daddr[5:0] + 6'h1], mem[i_daddr[5:0]]}
                     : ~o_ddata;
    o_pdata <= i_prd ? {mem[i_paddr[5:0] + 6'h1], mem[i_paddr[5:0]]}
                     : ~o_pdata;
    if (i_wr)
      mem[i_waddr[5:0]] <= i_wdata;
  end
endmodule
`default_nettype wire

/* testbench/dmp_exec_test.sv */
// Self-checking bench for the dual MAC, word move and protect unit
`timescale 1ns/1ns
`default_nettype none
`include "dmp_regs.vh"
module dmp_exec_test;
  logic I_CLK = 1'b0, I_RST = 1'b1, I_OP_VALID = 1'b0, I_REP_VALID = 1'b0;
  logic I_OPND_IS_REG = 1'b0, I_OPND_PTR7 = 1'b0, I_INT_ENTRY = 1'b0;
  logic I_IRQ_RET = 1'b0, I_DBG_OVR = 1'b0, I_DBG_PROT = 1'b0;
  logic I_WR = 1'b0, I_RD = 1'b0;
  logic [15:0] I_OP_WORD0 = 16'h0, I_OP_WORD1 = 16'h0, I_REP_N = 16'h0;
  logic [15:0] I_RET_STAT = 16'h0;
  logic [21:0] I_OPND_ADDR = 22'h0, I_OPND_STEP = 22'h0;
  logic [31:0] I_OPND_REG_DATA = 32'h0, I_WDATA = 32'h0;
  logic [2:0] I_ADDR = 3'h0;
  wire [31:0] I_DMEM_RDATA, I_PMEM_RDATA, O_RDATA;
  wire [21:0] O_DMEM_ADDR, O_DMEM_WADDR, O_PMEM_ADDR;
  wire [15:0] O_DMEM_WDATA, O_STAT_SAVE;
  wire O_DMEM_RD, O_DMEM_WR, O_PMEM_RD, O_IRQ_MASK, O_PROT_WR_OK;
  wire O_PROT_RD_OK, O_ILLEGAL_TRAP, O_BUSY;
  int err_count = 0, samples_checked = 0, traps = 0, k, j, st, inc;
  logic [31:0] seed = 32'h3ED6, a, p, x, y, b, hi, lo;
  logic [32:0] s;
  logic [5:0] t;
  logic v, c, ov, rd_q = 1'b0;
  logic [37:0] rq[$], wq[$];
  logic [15:0] img[0:63];

  dmp_exec dmp_exec_inst (.I_CLK, .I_RST, .I_OP_VALID, .I_OP_WORD0,
    .I_OP_WORD1, .I_REP_VALID, .I_REP_N, .I_OPND_ADDR, .I_OPND_STEP,
    .I_OPND_IS_REG, .I_OPND_REG_DATA, .I_OPND_PTR7, .O_DMEM_ADDR,
    .O_DMEM_RD, .I_DMEM_RDATA, .O_DMEM_WADDR, .O_DMEM_WR, .O_DMEM_WDATA,
    .O_PMEM_ADDR, .O_PMEM_RD, .I_PMEM_RDATA, .I_INT_ENTRY, .I_IRQ_RET,
    .I_RET_STAT, .I_DBG_OVR, .I_DBG_PROT, .O_STAT_SAVE, .O_IRQ_MASK,
    .O_PROT_WR_OK, .O_PROT_RD_OK, .O_ILLEGAL_TRAP, .O_BUSY, .I_ADDR,
    .I_WDATA, .I_WR, .I_RD, .O_RDATA);
  dmp_mem_model dmp_mem_model_inst (.i_clk(I_CLK), .i_daddr(O_DMEM_ADDR),
    .i_drd(O_DMEM_RD), .i_waddr(O_DMEM_WADDR), .i_wr(O_DMEM_WR),
    .i_wdata(O_DMEM_WDATA), .i_paddr(O_PMEM_ADDR), .i_prd(O_PMEM_RD),
    .o_ddata(I_DMEM_RDATA), .o_pdata(I_PMEM_RDATA));

  always #10 I_CLK = ~I_CLK;

  function automatic [31:0] lfsr(input [31:0] q);
    lfsr = {q[30:0], q[31] ^ q[21] ^ q[1] ^ q[0]};
  endfunction
  // Shift select 0 doubles, 1 passes, k shifts right arithmetically k-1
  function automatic [31:0] shp(input [31:0] w, input [2:0] sel);
    if (sel == 3'h0)
      shp = w << 1;
    else
      shp = $signed(w) >>> (sel - 3'h1);
  endfunction
  task automatic check(input [37:0] seen, input [37:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rw(input [2:0] ad, input [31:0] d, input wr);
    @(posedge I_CLK);
    I_ADDR <= ad;
    I_WDATA <= d;
    I_WR <= wr;
    I_RD <= !wr;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    I_RD <= 1'b0;
  endtask
  task automatic rd(input [2:0] ad, input [31:0] e);
    rq.push_back({6'h0, e});
    rw(ad, 32'h0, 1'b0);
  endtask
  // Offer one op, then wait a bounded time for the unit to go idle
  task automatic op(input [15:0] w0, input [15:0] w1, input rv,
    input [15:0] n, input [21:0] ad, input [21:0] st, input rg);
    int i;
    @(posedge I_CLK);
    I_OP_VALID <= 1'b1;
    I_OP_WORD0 <= w0;
    I_OP_WORD1 <= w1;
    I_REP_VALID <= rv;
    I_REP_N <= n;
    I_OPND_ADDR <= ad;
    I_OPND_STEP <= st;
    I_OPND_IS_REG <= rg;
    I_OPND_REG_DATA <= seed;
    @(posedge I_CLK);
    I_OP_VALID <= 1'b0;
    #1;
    i = 0;
    while (O_BUSY !== 1'b0 && i < 100)
    begin
      @(posedge I_CLK);
      #1;
      i++;
    end
    if (i == 100)
      err_count++;
  endtask
  task automatic fill();
    for (int i = 0; i < 64; i++)
    begin
      seed = lfsr(seed);
      img[i] = seed[15:0];
      dmp_mem_model_inst.mem[i] = seed[15:0];
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Each result is paired with the oldest note as it appears
  always @(posedge I_CLK)
  begin
    rd_q <= I_RD;
    if (rd_q)
      check({6'h0, O_RDATA}, rq.pop_front());
    if (O_DMEM_WR)
      check({O_DMEM_WADDR, O_DMEM_WDATA}, wq.pop_front());
    if (O_ILLEGAL_TRAP)
      traps++;
  end

  // The run needs fewer than 200 cycles; this cuts a hang short
  initial
  begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    repeat (5) @(posedge I_CLK);
    I_RST <= 1'b0;
    rd(`DMP_OFS_STAT, 32'h4000);
    rw(`DMP_OFS_REP, 32'hFFFF, 1'b1);
    rd(`DMP_OFS_REP, 32'h0);
    rd(3'h6, 32'h0);
    rw(`DMP_OFS_STAT, 32'h0, 1'b1);
    op(`DMP_OP_IDIS, 16'h0, 1'b1, 16'h3, 22'h0, 22'h0, 1'b0);
    check(O_IRQ_MASK, 1);
    rd(`DMP_OFS_STAT, 32'h4000);
    rd(`DMP_OFS_REP, 32'h0);
    // Shift select, saturation and pointer form vary with k
    for (k = 0; k < 4; k++)
    begin
      fill();
      a = lfsr(seed);
      p = lfsr(a);
      seed = p;
      // Odd k: data operand also steps pointer seven, by 4, and wins
      st = k[0] ? 4 : 2;
      inc = k[0] ? 4 : 2 * k[1];
      I_OPND_PTR7 <= k[0];
      rw(`DMP_OFS_STAT, 32'h4000 | (k << 1) | k[0], 1'b1);
      rw(`DMP_OFS_SUM, a, 1'b1);
      rw(`DMP_OFS_PRD, p, 1'b1);
      rw(`DMP_OFS_PTR7, 32'h20, 1'b1);
      t = 6'h0;
      v = 1'b0;
      c = 1'b0;
      for (j = 0; j < 2; j++)
      begin
        x = {img[9 + st * j], img[8 + st * j]};
        y = {img[33 + inc * j], img[32 + inc * j]};
        hi = $signed(x[31:16]) * $signed(y[31:16]);
        lo = $signed(x[15:0]) * $signed(y[15:0]);
        b = shp(hi, k[2:0]);
        s = {1'b0, a} + {1'b0, b};
        ov = (a[31] == b[31]) && (s[31] != a[31]);
        c = s[32];
        v = v | ov;
        if (ov && !k[0])
          t = a[31] ? t - 6'h1 : t + 6'h1;
        a = (ov && k[0]) ? (a[31] ? 32'h80000000 : 32'h7FFFFFFF) : s[31:0];
        p = p + shp(lo, k[2:0]);
      end
      op(`DMP_OP_MAC0, {k[1] ? `DMP_OP_MAC_PINC : `DMP_OP_MAC_PLAIN, 8'h0},
        1'b1, 16'h1, 22'h8, st[21:0], 1'b0);
      rd(`DMP_OFS_SUM, a);
      rd(`DMP_OFS_PRD, p);
      rd(`DMP_OFS_MCAND, x);
      rd(`DMP_OFS_PTR7, 32'h20 + 2 * inc);
      rd(`DMP_OFS_STAT, {16'h0, 2'b01, t, v, c, a[31], a == 32'h0,
        k[2:0], k[0]});
    end
    I_OPND_PTR7 <= 1'b0;
    wq.push_back({22'h16, img[21]});
    wq.push_back({22'h15, img[20]});
    op({`DMP_OP_MOV, 8'h0}, 16'h0, 1'b1, 16'h1, 22'h15, 22'h3FFFFF, 1'b0);
    op({`DMP_OP_MOV, 8'h0}, 16'h0, 1'b0, 16'h0, 22'h15, 22'h0, 1'b1);
    op(`DMP_OP_MAC0, 16'hC700, 1'b0, 16'h0, 22'h8, 22'h0, 1'b1);
    check(traps, 1);
    check(wq.size(), 0);
    op(`DMP_OP_PROT, 16'h0, 1'b1, 16'h2, 22'h0, 22'h0, 1'b0);
    check(O_PROT_WR_OK, 1);
    check(O_PROT_RD_OK, 1);
    check(O_STAT_SAVE[15], 1);
    @(posedge I_CLK);
    I_INT_ENTRY <= 1'b1;
    @(posedge I_CLK);
    I_INT_ENTRY <= 1'b0;
    #1;
    check(O_PROT_WR_OK, 0);
    @(posedge I_CLK);
    I_RET_STAT <= 16'h8000;
    I_IRQ_RET <= 1'b1;
    @(posedge I_CLK);
    I_IRQ_RET <= 1'b0;
    #1;
    check(O_PROT_WR_OK, 1);
    @(posedge I_CLK);
    I_DBG_OVR <= 1'b1;
    repeat (4) @(posedge I_CLK);
    #1;
    check(O_PROT_WR_OK, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
